// ### logic/icr_regs.svh
// offsets, field positions, reset values and constant fields of the command and status pair
`ifndef ICR_REGS_SVH
`define ICR_REGS_SVH

// ************************************************************
// register offsets in configuration space (byte addresses)
// ************************************************************
`define ICR_CMD_OFS        8'h04
`define ICR_STAT_OFS       8'h06

// ************************************************************
// command field positions
// ************************************************************
`define ICR_CMD_IO_BIT     0
`define ICR_CMD_MEM_BIT    1
`define ICR_CMD_INIT_BIT   2
`define ICR_CMD_RSV_HI     8
`define ICR_CMD_RSV_LO     3

// ************************************************************
// status field positions
// ************************************************************
`define ICR_STAT_MA_BIT    13
`define ICR_STAT_TA_BIT    11
`define ICR_STAT_SEL_HI    10
`define ICR_STAT_SEL_LO    9
`define ICR_STAT_FBB_BIT   7

// ************************************************************
// reset values and constant fields
// ************************************************************
`define ICR_CMD_RST        16'h0000
`define ICR_STAT_RST       16'h0280
`define ICR_STAT_CONST     16'h0280
`define ICR_SEL_TIMING     2'h1
`define ICR_ENA_RST        3'h0

`endif

// ### logic/icr_pkg.sv
// types shared by the command and status register modules
`default_nettype none

package icr_pkg;

	// state of the register bank
	typedef struct packed {
		logic [2:0]  ena;        // io, memory window, initiator enables
		logic        ma_seen;    // master abort seen
		logic        ta_sent;    // target abort sent
		logic [31:0] rdata;      // read answer
		logic        rvalid;     // read answer strobe
	} icr_bank_st_t;

	// state of the decode and interrupt gate
	typedef struct packed {
		logic irq;
		logic dec_pri;
		logic dec_sec;
		logic dec_bm;
		logic mem_win;
		logic init_en;
	} icr_gate_st_t;

endpackage

`default_nettype wire

// ### logic/icr_ctl_if.sv
// enables passed from the register bank to the decode and interrupt gate
`default_nettype none

interface icr_ctl_if;
	logic initiator_enable;
	logic mem_window_enable;
	logic io_decode_enable;

	modport bank (output initiator_enable, output mem_window_enable, output io_decode_enable);
	modport gate (input initiator_enable, input mem_window_enable, input io_decode_enable);
endinterface

`default_nettype wire

// ### logic/icr_gate.sv
// decode enables and native mode interrupt masking
`default_nettype none
`include "icr_regs.svh"

module icr_gate (
	// clock and reset
	input  wire logic  clk_sys,
	input  wire logic  rst,
	// enables from the register bank
	icr_ctl_if.gate    ctl,
	// function side
	input  wire logic  irq_req,
	input  wire logic [1:0] native_sel,
	input  wire logic [1:0] chan_decode_en,
	// registered results
	output logic       irq_out,
	output logic       dec_pri,
	output logic       dec_sec,
	output logic       dec_bm,
	output logic       mem_win,
	output logic       init_en
);

	icr_pkg::icr_gate_st_t st_r;
	icr_pkg::icr_gate_st_t st_nxt;
	logic                  native;
	logic                  masked;

	// ************************************************************
	// next state
	// ************************************************************
	// the mask works on the level, so a request held through the mask shows up once it lifts
	always_comb begin
		// [R17] either select bit means native
		native = |native_sel;
		// [R8] io decode off in native mode
		masked = native & ~ctl.io_decode_enable;
		st_nxt = st_r;
		// [R9] pending request passes when unmasked
		st_nxt.irq = irq_req & ~masked;
		// [R5] io enable gates every range
		// [R7] per channel decode bits
		st_nxt.dec_pri = ctl.io_decode_enable & chan_decode_en[0];
		st_nxt.dec_sec = ctl.io_decode_enable & chan_decode_en[1];
		st_nxt.dec_bm  = ctl.io_decode_enable;
		// [R2] memory window decode
		st_nxt.mem_win = ctl.mem_window_enable;
		// [R1] initiator permission
		st_nxt.init_en = ctl.initiator_enable;
	end

	// registered state, cleared by reset
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign irq_out = st_r.irq;
	assign dec_pri = st_r.dec_pri;
	assign dec_sec = st_r.dec_sec;
	assign dec_bm  = st_r.dec_bm;
	assign mem_win = st_r.mem_win;
	assign init_en = st_r.init_en;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	property p_irq_mask;
		(|native_sel && !ctl.io_decode_enable) |=> !irq_out;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("interrupt not masked"); // [R8]

	property p_irq_unmask;
		(irq_req && !(|native_sel && !ctl.io_decode_enable)) |=> irq_out;
	endproperty
	a_irq_unmask: assert property (p_irq_unmask) else $error("held request not passed"); // [R9]

	property p_io_off;
		!ctl.io_decode_enable |=> !dec_pri && !dec_sec && !dec_bm;
	endproperty
	a_io_off: assert property (p_io_off) else $error("decode while io disabled"); // [R5]

	property p_chan_off;
		(ctl.io_decode_enable && !chan_decode_en[1]) |=> !dec_sec && dec_bm;
	endproperty
	a_chan_off: assert property (p_chan_off) else $error("channel decode bit ignored"); // [R7]

	property p_legacy;
		(native_sel == 2'h0 && irq_req) |=> irq_out;
	endproperty
	a_legacy: assert property (p_legacy) else $error("legacy request masked"); // [R17]

endmodule

`default_nettype wire

// ### logic/icr_bank.sv
// command and status register pair of the disk controller function
// Functional notes
// [R1] Command bit 2 enables initiator transfers.
// [R2] Command bit 1 enables memory window decode.
// [R3] Software loads expansion base before memory enable.
// [R4] Firmware should set memory enable at init.
// [R5] I/O enable zero blocks all port decode.
// [R6] Software programs master base before I/O enable.
// [R7] Per-channel decode bits disable ranges independently.
// [R8] Native mode, I/O off: interrupt held low.
// [R9] Request still active after unmask gets asserted.
// [R10] Command bits 8 to 3 read zero.
// [R11] Master abort sets status bit 13.
// [R12] Target abort sets status bit 11.
// [R13] Bits 13, 11 clear by writing one.
// [R14] Select timing bits 10:9 read 01.
// [R15] Status bit 7 reads one.
// [R16] Status bits 15,14,12,8,6,5 read zero.
// [R17] Programming-interface bits 0, 2 select native.
// [R18] Read-only writes ignored; writable bits reset zero.
`default_nettype none
`include "icr_regs.svh"

module icr_bank (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// configuration access, one dword at a time
	input  wire logic        cfg_rd,
	input  wire logic        cfg_wr,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [3:0]  cfg_be,
	input  wire logic [31:0] cfg_wdata,
	output logic [31:0]      cfg_rdata,
	output logic             cfg_rvalid,
	// events from the function
	input  wire logic        master_abort_evt,
	input  wire logic        target_abort_evt,
	input  wire logic        irq_req,
	// mode and channel controls from neighbouring registers
	input  wire logic [1:0]  native_sel,
	input  wire logic [1:0]  chan_decode_en,
	// results
	output logic             irq_out,
	output logic             io_decode_pri,
	output logic             io_decode_sec,
	output logic             io_decode_bm,
	output logic             mem_window_decode,
	output logic             initiator_enable
);

	icr_pkg::icr_bank_st_t st_r;
	icr_pkg::icr_bank_st_t st_nxt;
	logic                  hit;
	logic [15:0]           stat_view;
	logic [15:0]           cmd_view;

	icr_ctl_if ctl ();

	// ************************************************************
	// helpers
	// ************************************************************
	// both registers share one aligned dword
	function automatic logic dword_hit(input logic [7:0] a);
		dword_hit = (a[7:2] == 6'(`ICR_CMD_OFS >> 2));
	endfunction

	// status word as software sees it
	function automatic logic [15:0] stat_word(input logic ma, input logic ta);
		logic [15:0] w;
		w = `ICR_STAT_CONST;
		w[`ICR_STAT_MA_BIT] = ma;
		w[`ICR_STAT_TA_BIT] = ta;
		stat_word = w;
	endfunction

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		hit      = dword_hit(cfg_addr);
		st_nxt   = st_r;
		// [R10] bits above the enables stay zero
		cmd_view = {13'h0000, st_r.ena};
		// [R14] [R15] [R16] constant fields come from one word
		stat_view = stat_word(st_r.ma_seen, st_r.ta_sent);
		// [R1] [R2] [R5] enables written through lane 0
		// [R18] other command bits have no storage
		if (cfg_wr && hit && cfg_be[0]) begin
			st_nxt.ena = cfg_wdata[2:0];
		end
		// [R13] write one clears, zero keeps
		if (cfg_wr && hit && cfg_be[3]) begin
			if (cfg_wdata[16 + `ICR_STAT_MA_BIT]) begin
				st_nxt.ma_seen = 1'b0;
			end
			if (cfg_wdata[16 + `ICR_STAT_TA_BIT]) begin
				st_nxt.ta_sent = 1'b0;
			end
		end
		// [R11] set after clear so a same-cycle event wins
		if (master_abort_evt) begin
			st_nxt.ma_seen = 1'b1;
		end
		// [R12] target abort flag
		if (target_abort_evt) begin
			st_nxt.ta_sent = 1'b1;
		end
		// unmapped dwords read zero
		st_nxt.rvalid = cfg_rd;
		st_nxt.rdata  = (cfg_rd && hit) ? {stat_view, cmd_view} : 32'h0000_0000;
	end

	// [R18] writable bits reset to zero
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign cfg_rdata  = st_r.rdata;
	assign cfg_rvalid = st_r.rvalid;

	// ************************************************************
	// enables to the gate
	// ************************************************************
	assign ctl.io_decode_enable  = st_r.ena[`ICR_CMD_IO_BIT];
	assign ctl.mem_window_enable = st_r.ena[`ICR_CMD_MEM_BIT];
	assign ctl.initiator_enable  = st_r.ena[`ICR_CMD_INIT_BIT];

	// one cycle later than the register; decode never runs ahead of the enable
	icr_gate u_gate (
		.clk_sys        (clk_sys),
		.rst            (rst),
		.ctl            (ctl),
		.irq_req        (irq_req),
		.native_sel     (native_sel),
		.chan_decode_en (chan_decode_en),
		.irq_out        (irq_out),
		.dec_pri        (io_decode_pri),
		.dec_sec        (io_decode_sec),
		.dec_bm         (io_decode_bm),
		.mem_win        (mem_window_decode),
		.init_en        (initiator_enable)
	);

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	property p_init_wr;
		(cfg_wr && hit && cfg_be[0]) |=> ##1 (initiator_enable == $past(cfg_wdata[2], 2));
	endproperty
	a_init_wr: assert property (p_init_wr) else $error("initiator enable not taken"); // [R1]

	property p_mem_wr;
		(cfg_wr && hit && cfg_be[0]) |=> ##1 (mem_window_decode == $past(cfg_wdata[1], 2));
	endproperty
	a_mem_wr: assert property (p_mem_wr) else $error("memory enable not taken"); // [R2]

	property p_cmd_ro;
		(cfg_rd && hit) |=> (cfg_rdata[8:3] == 6'h00 && cfg_rdata[15:9] == 7'h00);
	endproperty
	a_cmd_ro: assert property (p_cmd_ro) else $error("command reserved bits not zero"); // [R10]

	property p_ma_set;
		master_abort_evt |=> st_r.ma_seen;
	endproperty
	a_ma_set: assert property (p_ma_set) else $error("master abort not recorded"); // [R11]

	property p_ta_set;
		target_abort_evt |=> st_r.ta_sent;
	endproperty
	a_ta_set: assert property (p_ta_set) else $error("target abort not recorded"); // [R12]

	property p_w1c;
		(cfg_wr && hit && cfg_be[3] && !cfg_wdata[29] && !master_abort_evt) |=> $stable(st_r.ma_seen);
	endproperty
	a_w1c: assert property (p_w1c) else $error("zero write changed abort flag"); // [R13]

	property p_w1c_clr;
		(cfg_wr && hit && cfg_be[3] && cfg_wdata[27] && !target_abort_evt) |=> !st_r.ta_sent;
	endproperty
	a_w1c_clr: assert property (p_w1c_clr) else $error("one write did not clear"); // [R13]

	property p_sel;
		(cfg_rd && hit) |=> (cfg_rdata[26:25] == 2'h1 && cfg_rvalid);
	endproperty
	a_sel: assert property (p_sel) else $error("select timing wrong"); // [R14]

	property p_fbb;
		(cfg_rd && hit) |=> cfg_rdata[23];
	endproperty
	a_fbb: assert property (p_fbb) else $error("back-to-back bit not one"); // [R15]

	property p_sts_ro;
		(cfg_rd && hit) |=> (cfg_rdata[31:30] == 2'h0 && !cfg_rdata[28] && !cfg_rdata[24] && cfg_rdata[22:16] == 7'h00);
	endproperty
	a_sts_ro: assert property (p_sts_ro) else $error("status zero bits set"); // [R16]

	property p_reset;
		$fell(rst) |-> (st_r.ena == 3'h0 && !st_r.ma_seen && !st_r.ta_sent);
	endproperty
	a_reset: assert property (p_reset) else $error("writable bits not cleared"); // [R18]

	property p_ma_win;
		(master_abort_evt && cfg_wr && hit && cfg_be[3] && cfg_wdata[29]) |=> st_r.ma_seen;
	endproperty
	a_ma_win: assert property (p_ma_win) else $error("clear beat a same-cycle abort"); // [R11]

	property p_cmd_keep;
		(cfg_wr && hit && !cfg_be[0]) |=> $stable(st_r.ena);
	endproperty
	a_cmd_keep: assert property (p_cmd_keep) else $error("enables changed without lane 0"); // [R18]

	property p_unmapped;
		(cfg_rd && !hit) |=> (cfg_rdata == 32'h0000_0000 && cfg_rvalid);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero"); // [R18]

endmodule

`default_nettype wire

// ### test/icr_fn_mdl.sv
// function side model that raises abort events toward the bank
`default_nettype none
module icr_fn_mdl (
	// permission from the bank
	input  wire logic initiator_enable,
	// scenario commands
	input  wire logic ma_go,
	input  wire logic ta_go,
	// events to the bank
	output logic      master_abort_evt,
	output logic      target_abort_evt
);
	timeunit 1ns;
	timeprecision 1ps;
	// no initiator cycle, so no master abort, while not permitted
	assign master_abort_evt = ma_go & initiator_enable;
	// target aborts come from incoming cycles, never gated
	assign target_abort_evt = ta_go;
endmodule
`default_nettype wire

// ### test/ide_pci_command_status_regs_tb.sv
// self-checking bench for the command and status pair
`default_nettype none
module ide_pci_command_status_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************************
	// signals
	// ************************************************************
	logic        clk_sys, rst, cfg_rd, cfg_wr, irq_req, ma_go, ta_go;
	logic [7:0]  cfg_addr;
	logic [3:0]  cfg_be;
	logic [31:0] cfg_wdata, cfg_rdata;
	logic [1:0]  native_sel, chan_decode_en;
	logic        cfg_rvalid, master_abort_evt, target_abort_evt, irq_out;
	logic        io_decode_pri, io_decode_sec, io_decode_bm;
	logic        mem_window_decode, initiator_enable;
	logic [5:0]  outs;
	int          num_errors, check_count;
	// result vector: irq, pri, sec, bm, mem, init
	assign outs = {irq_out, io_decode_pri, io_decode_sec, io_decode_bm, mem_window_decode, initiator_enable};
	icr_bank u_dut (.clk_sys, .rst, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata,
		.cfg_rvalid, .master_abort_evt, .target_abort_evt, .irq_req, .native_sel, .chan_decode_en,
		.irq_out, .io_decode_pri, .io_decode_sec, .io_decode_bm, .mem_window_decode, .initiator_enable);
	icr_fn_mdl u_mdl (.initiator_enable, .ma_go, .ta_go, .master_abort_evt, .target_abort_evt);
	// ************************************************************
	// tasks
	// ************************************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// write returns once the decode outputs have settled
	task automatic wr(input logic [3:0] be, input logic [31:0] d);
		cfg_wr = 1'b1;
		cfg_addr = 8'h04;
		cfg_be = be;
		cfg_wdata = d;
		@(negedge clk_sys);
		cfg_wr = 1'b0;
		@(negedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		cfg_rd = 1'b1;
		cfg_addr = a;
		@(negedge clk_sys);
		cfg_rd = 1'b0;
		chk({31'h0, cfg_rvalid}, 32'h1);
		chk(cfg_rdata, exp);
		// one idle cycle so a following read does not reassign the strobe in this step
		@(negedge clk_sys);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// ************************************************************
	// clock, watchdog and tests
	// ************************************************************
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// the whole sequence needs well under 100 cycles
	initial begin
		#5000;
		num_errors++;
		wrap_up();
	end
	initial begin
		{rst, cfg_rd, cfg_wr, irq_req, ma_go, ta_go} = 6'h20;
		{cfg_addr, cfg_be, cfg_wdata, native_sel, chan_decode_en} = '0;
		num_errors = 0;
		check_count = 0;
		repeat (6) @(negedge clk_sys);
		rst = 1'b0;
		rd(8'h04, 32'h0280_0000);
		chk({26'h0, outs}, 32'h0);
		$display("test reset values done");
		chan_decode_en = 2'b01;
		// base registers outside this block count as loaded first
		wr(4'hf, 32'hffff_ffff);
		rd(8'h04, 32'h0280_0007);
		chk({26'h0, outs}, 32'h17);
		$display("test enables done");
		// request held while masked must come out on unmask
		native_sel = 2'b10;
		chan_decode_en = 2'b11;
		irq_req = 1'b1;
		wr(4'h1, 32'h6);
		chk({26'h0, outs}, 32'h03);
		wr(4'h1, 32'h7);
		chk({26'h0, outs}, 32'h3f);
		native_sel = 2'b00;
		wr(4'h1, 32'h6);
		chk({26'h0, outs}, 32'h23);
		// primary select bit alone also means native
		native_sel = 2'b01;
		@(negedge clk_sys);
		chk({26'h0, outs}, 32'h03);
		$display("test decode and interrupt done");
		ma_go = 1'b1;
		ta_go = 1'b1;
		@(negedge clk_sys);
		{ma_go, ta_go} = 2'b00;
		rd(8'h04, 32'h2a80_0006);
		wr(4'hf, 32'h0000_0006);
		rd(8'h04, 32'h2a80_0006);
		wr(4'h8, 32'h2800_0000);
		rd(8'h04, 32'h0280_0006);
		// an abort in the very cycle of its clear must survive
		ma_go = 1'b1;
		fork
			wr(4'h8, 32'h2000_0000);
			begin
				@(negedge clk_sys);
				ma_go = 1'b0;
			end
		join
		rd(8'h04, 32'h2280_0006);
		wr(4'h8, 32'h2000_0000);
		rd(8'h04, 32'h0280_0006);
		// with initiator off the model cannot see a master abort
		wr(4'h1, 32'h3);
		ma_go = 1'b1;
		@(negedge clk_sys);
		ma_go = 1'b0;
		rd(8'h04, 32'h0280_0003);
		rd(8'h08, 32'h0);
		$display("test status events done");
		// a second reset in mid-run clears the enables again
		rst = 1'b1;
		repeat (2) @(negedge clk_sys);
		rst = 1'b0;
		rd(8'h04, 32'h0280_0000);
		chk({26'h0, outs}, 32'h0);
		$display("test mid-run reset done");
		wrap_up();
	end
endmodule
`default_nettype wire
